// ===== pkg/adccs_pkg.sv
`default_nettype none
package adccs_pkg;
    // ****************************************
    // Bus and map
    // ****************************************
    localparam int ADCCS_AW = 4;
    localparam logic [ADCCS_AW-1:0] ADCCS_CHSEL_OFS = 4'h0;
    localparam logic [ADCCS_AW-1:0] ADCCS_CTRL_OFS = 4'h4;
    localparam logic [ADCCS_AW-1:0] ADCCS_ACTIVE_OFS = 4'h8;
    localparam logic [31:0] ADCCS_UNMAPPED_VAL = 32'h0000_0000;
    // ****************************************
    // Fields
    // ****************************************
    localparam int ADCCS_MASK_LSB = 0;
    localparam int ADCCS_MASK_MSB = 7;
    localparam int ADCCS_SRC_LSB = 8;
    localparam int ADCCS_SRC_MSB = 9;
    localparam int ADCCS_DIFF_BIT = 10;
    localparam int ADCCS_NCH = 8;
    localparam logic [7:0] ADCCS_MASK_RST = 8'h00;
    localparam logic [7:0] ADCCS_EVEN_CH = 8'h55;
    typedef enum logic [1:0] {
        ADCCS_SRC_PIN = 2'h0,
        ADCCS_SRC_BANDGAP = 2'h1
    } adccs_src_t;
    typedef enum {ADCCS_IDLE, ADCCS_RESP} adccs_phase_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADCCS_AW-1:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } adccs_req_t;

    typedef struct packed {
        logic [7:0] channel_enable_mask;
        logic [1:0] channel7_source_select;
        logic differential_mode_bit;
    } adccs_cfg_t;

    // Merge byte lanes into an old word
    function automatic logic [31:0] adccs_merge(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction
endpackage
`default_nettype wire

// ===== rtl/adccs_chan_decode.sv
`default_nettype none
module adccs_chan_decode (
    // Configuration
    input wire adccs_pkg::adccs_cfg_t cfg,
    // Decoded channel state
    output logic [7:0] active,
    output logic ch7_bandgap,
    output logic ch7_pin
);
    import adccs_pkg::*;
    always_comb begin
        // ****************************************
        // per-channel enable
        // cleared bit excludes
        // ****************************************
        active = cfg.channel_enable_mask;
        if (cfg.differential_mode_bit) begin
            active = cfg.channel_enable_mask & ADCCS_EVEN_CH;
        end
        ch7_pin = (cfg.channel7_source_select == ADCCS_SRC_PIN);
        ch7_bandgap = (cfg.channel7_source_select == ADCCS_SRC_BANDGAP);
    end
endmodule
`default_nettype wire

// ===== rtl/adccs_chsel.sv
// The address map and register access over Avalon-MM were left to the implementer.
`default_nettype none
module adccs_chsel (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [adccs_pkg::ADCCS_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // To converter sequencer and analog mux
    output logic [7:0] chan_active,
    output logic ch7_sel_bandgap,
    output logic ch7_sel_pin,
    output logic differential_mode
);
    import adccs_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        adccs_phase_t phase;
        adccs_cfg_t cfg;
        logic [31:0] rdata;
        logic waitreq;
        logic [7:0] active;
        logic bg;
        logic pin;
        logic diff;
    } adccs_state_t;

    adccs_state_t s_q, s_d;
    adccs_req_t req;
    logic [7:0] dec_active;
    logic dec_bg, dec_pin;
    logic [31:0] chsel_word, ctrl_word, nw;

    assign req = '{read: avs_read, write: avs_write, address: avs_address,
                   writedata: avs_writedata, byteenable: avs_byteenable};

    adccs_chan_decode u_dec (
        .cfg(s_q.cfg),
        .active(dec_active),
        .ch7_bandgap(dec_bg),
        .ch7_pin(dec_pin)
    );

    assign chsel_word = {22'h00_0000, s_q.cfg.channel7_source_select, s_q.cfg.channel_enable_mask};
    assign ctrl_word = {21'h00_0000, s_q.cfg.differential_mode_bit, 10'h000};

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        nw = 32'h0000_0000;
        s_d.waitreq = 1'b1;
        s_d.active = dec_active;
        s_d.bg = dec_bg;
        s_d.pin = dec_pin;
        // Mode flag moves with chan_active, so odd bits never show in mode
        s_d.diff = s_q.cfg.differential_mode_bit;
        case (s_q.phase)
            ADCCS_IDLE: begin
                // One wait state, then answer
                if (req.read || req.write) begin
                    s_d.phase = ADCCS_RESP;
                    s_d.waitreq = 1'b0;
                    s_d.rdata = ADCCS_UNMAPPED_VAL;
                    if (req.read) begin
                        case (req.address)
                            ADCCS_CHSEL_OFS: s_d.rdata = chsel_word;
                            ADCCS_CTRL_OFS: s_d.rdata = ctrl_word;
                            ADCCS_ACTIVE_OFS: s_d.rdata = {24'h00_0000, s_q.active};
                            default: s_d.rdata = ADCCS_UNMAPPED_VAL;
                        endcase
                    end
                    if (req.write) begin
                        case (req.address)
                            ADCCS_CHSEL_OFS: begin
                                nw = adccs_merge(chsel_word, req.writedata, req.byteenable);
                                s_d.cfg.channel_enable_mask = nw[ADCCS_MASK_MSB:ADCCS_MASK_LSB];
                                s_d.cfg.channel7_source_select = nw[ADCCS_SRC_MSB:ADCCS_SRC_LSB];
                            end
                            ADCCS_CTRL_OFS: begin
                                nw = adccs_merge(ctrl_word, req.writedata, req.byteenable);
                                s_d.cfg.differential_mode_bit = nw[ADCCS_DIFF_BIT];
                            end
                            default: s_d.cfg = s_q.cfg;
                        endcase
                    end
                end
            end
            ADCCS_RESP: begin
                // Master releases the request at this edge
                s_d.phase = ADCCS_IDLE;
            end
            default: s_d.phase = ADCCS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '{phase: ADCCS_IDLE,
                     cfg: '{channel_enable_mask: ADCCS_MASK_RST,
                            channel7_source_select: ADCCS_SRC_PIN,
                            differential_mode_bit: 1'b0},
                     rdata: 32'h0000_0000, waitreq: 1'b1, active: 8'h00, bg: 1'b0, pin: 1'b1, diff: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.waitreq;
    assign chan_active = s_q.active;
    assign ch7_sel_bandgap = s_q.bg;
    assign ch7_sel_pin = s_q.pin;
    assign differential_mode = s_q.diff;
endmodule
`default_nettype wire

// ===== sim/adccs_sva.sv
`default_nettype none
module adccs_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Channel state
    input wire logic [7:0] chan_active,
    input wire logic ch7_sel_bandgap,
    input wire logic ch7_sel_pin,
    input wire logic differential_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic we;
    logic w0;
    assign we = avs_write && !avs_waitrequest;
    assign w0 = we && avs_address == 4'h0;
    a_sel_one: assert property (!(ch7_sel_pin && ch7_sel_bandgap)) else $error("both");
    a_src_gap: assert property (w0 && avs_byteenable[1] && avs_writedata[9:8] == 2'h1 |=> ch7_sel_bandgap)
        else $error("gap");
    a_src_pin: assert property (w0 && avs_byteenable[1] && avs_writedata[9:8] == 2'h0 |=> ch7_sel_pin)
        else $error("pin");
    a_mask_set: assert property (w0 && avs_byteenable[0] && !differential_mode
        |=> chan_active == $past(avs_writedata[7:0])) else $error("mask");
    a_mask_hold: assert property ($past(rst_n) && !$stable(chan_active) |-> $past(we)) else $error("hold");
    a_diff_odd: assert property (differential_mode |-> (chan_active & 8'hAA) == 8'h00) else $error("odd");
    a_diff_set: assert property (we && avs_address == 4'h4 && avs_byteenable[1]
        |=> differential_mode == $past(avs_writedata[10])) else $error("diff");
    a_rsvd_zero: assert property (!avs_waitrequest && avs_read && avs_address == 4'h0
        |-> avs_readdata[31:10] == 22'h0) else $error("rsvd");
endmodule
bind adccs_chsel adccs_sva i_adccs_sva (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .chan_active, .ch7_sel_bandgap, .ch7_sel_pin,
    .differential_mode);
`default_nettype wire

// ===== sim/adccs_mux_model.sv
`default_nettype none
module adccs_mux_model (
    // From selector
    input wire logic [7:0] chan_active,
    // Count of converted inputs
    output logic [3:0] conv_count
);
    always_comb begin
        conv_count = 4'h0;
        for (int i = 0; i < 8; i++) begin
            conv_count = conv_count + {3'h0, chan_active[i]};
        end
    end
endmodule
`default_nettype wire

// ===== sim/adccs_chsel_test.sv
`default_nettype none
module adccs_chsel_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic [31:0] q;
    logic avs_waitrequest;
    logic [7:0] chan_active;
    logic ch7_sel_bandgap;
    logic ch7_sel_pin;
    logic differential_mode;
    logic [3:0] conv_count;
    int err_total = 0;
    int check_count = 0;
    always #5 clk = ~clk;
    adccs_chsel i_adccs_chsel (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .chan_active, .ch7_sel_bandgap, .ch7_sel_pin,
        .differential_mode);
    adccs_mux_model i_adccs_mux_model (.chan_active, .conv_count);
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Request held until waitrequest is sampled low at a rising edge
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= b;
        avs_write <= w;
        avs_read <= !w;
        n = 0;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20) begin
            err_total++;
            test_done();
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // Ends mid-cycle so outputs are settled for the caller
        @(negedge clk);
    endtask
    task automatic t_mask;
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, 4'h0, {24'h0, 8'h01 << i}, 4'hF);
            chk(chan_active, {24'h0, 8'h01 << i});
            chk(conv_count, 32'h0000_0001);
        end
        acc(1'b1, 4'h0, 32'h0000_0000, 4'hF);
        chk(chan_active, 32'h0000_0000);
        $display("t_mask end");
    endtask
    task automatic t_src;
        acc(1'b1, 4'h0, 32'h0000_01A5, 4'hF);
        chk({ch7_sel_pin, ch7_sel_bandgap}, 32'h0000_0001);
        acc(1'b1, 4'h0, 32'h0000_0000, 4'h1);
        chk({ch7_sel_bandgap, chan_active}, 32'h0000_0100);
        acc(1'b1, 4'h0, 32'hFFFF_FCFF, 4'hF);
        acc(1'b0, 4'h0, 32'h0000_0000, 4'hF);
        chk(q, 32'h0000_00FF);
        chk({ch7_sel_pin, ch7_sel_bandgap}, 32'h0000_0002);
        acc(1'b1, 4'h0, 32'h0000_01FF, 4'hF);
        chk({ch7_sel_pin, ch7_sel_bandgap}, 32'h0000_0001);
        $display("t_src end");
    endtask
    task automatic t_diff;
        acc(1'b1, 4'h4, 32'h0000_0400, 4'hF);
        chk({differential_mode, chan_active}, 32'h0000_0155);
        chk(conv_count, 32'h0000_0004);
        acc(1'b0, 4'h4, 32'h0000_0000, 4'hF);
        chk(q, 32'h0000_0400);
        acc(1'b0, 4'hC, 32'h0000_0000, 4'hF);
        chk(q, 32'h0000_0000);
        acc(1'b1, 4'h4, 32'h0000_0000, 4'hF);
        acc(1'b1, 4'h8, 32'h0000_0000, 4'hF);
        acc(1'b0, 4'h8, 32'h0000_0000, 4'hF);
        chk(q, 32'h0000_00FF);
        $display("t_diff end");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk({ch7_sel_pin, chan_active}, 32'h0000_0100);
        t_mask();
        t_src();
        t_diff();
        test_done();
    end
endmodule
`default_nettype wire
